// ==== nsi_map.svh ====
`ifndef NSI_MAP_SVH
`define NSI_MAP_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define NSI_ADR_W 8
`define NSI_OFS_STATUS 8'h00
`define NSI_OFS_CTRL 8'h04
`define NSI_OFS_IRQ_STAT 8'h08
`define NSI_OFS_IRQ_EN 8'h0C
`define NSI_OFS_IRQ_CLR 8'h10

// ----------------------------------------
// field positions
// ----------------------------------------
`define NSI_ST_TX 0
`define NSI_ST_COL 1
`define NSI_ST_LINK_GOOD 2
`define NSI_ST_LINK_DIS 3
`define NSI_ST_AUI 4
`define NSI_ST_SQ_RED 5
`define NSI_ST_TEST 6
`define NSI_ST_W 7
`define NSI_CTRL_IND_EN 0
`define NSI_CTRL_CLK_EN 1
`define NSI_CTRL_W 2
`define NSI_IRQ_TX 0
`define NSI_IRQ_COL 1
`define NSI_IRQ_LINK 2
`define NSI_IRQ_W 3
`define NSI_PIN_LINK 0
`define NSI_PIN_PORT 1
`define NSI_PIN_SQ 2
`define NSI_PIN_TEST 3
`define NSI_PIN_W 4

// ----------------------------------------
// reset values
// ----------------------------------------
`define NSI_CTRL_RST 2'h3
`define NSI_IRQ_EN_RST 3'h0

// ----------------------------------------
// timing: 50 ms pulse, 40000 kHz clock
// ----------------------------------------
`define NSI_STRETCH_MS 32'h0000_0032
`define NSI_CLK_KHZ 32'h0000_9C40
`define NSI_STRETCH_W 21

`endif

// ==== nsi_pkg.sv ====
`default_nettype none

package nsi_pkg;

  typedef struct packed {
    logic col;
    logic tx;
  } ind_evt_t;

  typedef enum logic {
    ST_RESET,
    ST_RUN
  } run_state_t;

  typedef struct packed {
    logic test;
    logic sq_red;
    logic aui;
    logic link_dis;
    logic link_good;
    logic col;
    logic tx;
  } nsi_status_t;

endpackage

`default_nettype wire

// ==== event_stretcher.sv ====
`include "nsi_map.svh"
`default_nettype none

module event_stretcher #(
  parameter logic [`NSI_STRETCH_W-1:0] CYCLES = `NSI_STRETCH_W'(`NSI_STRETCH_MS * `NSI_CLK_KHZ)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // event and stretched level
  input wire logic trig_i,
  output logic active_o
);

  logic [`NSI_STRETCH_W-1:0] cnt_ff;
  logic active_ff;

  // ----------------------------------------
  // retriggerable down counter
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
    end else if (trig_i) begin
      cnt_ff <= CYCLES;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_ff <= 1'b0;
    end else if (trig_i) begin
      active_ff <= 1'b1;
    end else if (cnt_ff == `NSI_STRETCH_W'(1)) begin
      active_ff <= 1'b0;
    end
  end

  assign active_o = active_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_retrig;
    trig_i |=> (cnt_ff == CYCLES) && active_ff;
  endproperty
  a_retrig: assert property (p_retrig) else $error("stretch not restarted");

  property p_level_tracks_count;
    active_ff == (cnt_ff != '0);
  endproperty
  a_level_tracks_count: assert property (p_level_tracks_count) else $error("level and count disagree");

  c_retrigger: cover property (active_ff && trig_i);

endmodule

`default_nettype wire

// ==== network_status_indicators.sv ====
// Notes on behaviour
// - transmit indicator goes high about 50 ms per transmission, either port.
// - collision indicator goes high about 50 ms per collision, either port.
// - link pin role is decided by one sample at reset release.
// - as output, link pin pulled low while link good, released when broken.
// - with the attachment-unit port selected the good-link output stays released.
// - link pin low at reset release makes it input and disables link checking.
// - squelch select low gives standard threshold, high or open gives reduced.
// - a buffered 20 MHz clock is driven on its own output.
// - port select high routes coding to attachment port, low to twisted pair.
// - chip reset acts at once; its release is the link sampling moment. Here reset is synchronous and acts on the next clk_i rising edge.
//
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
`include "nsi_map.svh"
`default_nettype none

module network_status_indicators #(
  parameter logic [`NSI_STRETCH_W-1:0] STRETCH_CYCLES = `NSI_STRETCH_W'(`NSI_STRETCH_MS * `NSI_CLK_KHZ)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`NSI_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  // events from controller and transceiver
  input wire logic tx_event_i,
  input wire logic col_event_i,
  input wire logic link_good_i,
  // board pins
  input wire logic link_good_or_disable_i,
  output logic link_good_or_disable_o,
  output logic link_good_or_disable_oe_o,
  input wire logic port_select_i,
  input wire logic squelch_level_select_i,
  input wire logic factory_test_i,
  // indicator and control outputs
  output logic transmit_activity_out_o,
  output logic collision_out_o,
  output logic clk20_o,
  output logic aui_select_o,
  output logic squelch_reduced_o,
  output logic link_check_en_o
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [`NSI_PIN_W-1:0] pin_meta_ff;
  logic [`NSI_PIN_W-1:0] pin_sync_ff;
  logic [`NSI_PIN_W-1:0] pin_raw;

  assign pin_raw = {factory_test_i, squelch_level_select_i, port_select_i, link_good_or_disable_i};

  // free running through reset so the release sample is settled
  always_ff @(posedge clk_i) begin
    pin_meta_ff <= pin_raw;
    pin_sync_ff <= pin_meta_ff;
  end

  logic link_pin_s;
  logic port_s;
  logic sq_s;
  logic test_s;

  assign link_pin_s = pin_sync_ff[`NSI_PIN_LINK];
  assign port_s = pin_sync_ff[`NSI_PIN_PORT];
  assign sq_s = pin_sync_ff[`NSI_PIN_SQ];
  assign test_s = pin_sync_ff[`NSI_PIN_TEST];

  // ----------------------------------------
  // reset release and link pin role
  // ----------------------------------------
  nsi_pkg::run_state_t state_ff;
  logic link_disable_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= nsi_pkg::ST_RESET;
    end else begin
      case (state_ff)
        nsi_pkg::ST_RESET: state_ff <= nsi_pkg::ST_RUN;
        nsi_pkg::ST_RUN: state_ff <= nsi_pkg::ST_RUN;
        default: state_ff <= nsi_pkg::ST_RESET;
      endcase
    end
  end

  // one sample, taken on the first edge after release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_disable_ff <= 1'b0;
    end else if (state_ff == nsi_pkg::ST_RESET) begin
      link_disable_ff <= ~link_pin_s;
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  logic [`NSI_CTRL_W-1:0] ctrl_ff;
  logic ind_en;
  logic clk_en;

  assign ind_en = ctrl_ff[`NSI_CTRL_IND_EN];
  assign clk_en = ctrl_ff[`NSI_CTRL_CLK_EN];

  // ----------------------------------------
  // indicator stretchers
  // ----------------------------------------
  nsi_pkg::ind_evt_t evt_trig;
  nsi_pkg::ind_evt_t evt_active;

  assign evt_trig.tx = tx_event_i & ind_en;
  assign evt_trig.col = col_event_i & ind_en;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_stretch
      event_stretcher #(
        .CYCLES(STRETCH_CYCLES)
      ) u_stretch (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .trig_i(evt_trig[g]),
        .active_o(evt_active[g])
      );
    end
  endgenerate

  assign transmit_activity_out_o = evt_active.tx;
  assign collision_out_o = evt_active.col;

  // ----------------------------------------
  // good-link open-drain driver
  // ----------------------------------------
  logic led_on;

  assign led_on = (state_ff == nsi_pkg::ST_RUN) & ~link_disable_ff & ~port_s & link_good_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_good_or_disable_oe_o <= 1'b0;
    end else begin
      link_good_or_disable_oe_o <= led_on;
    end
  end

  // driver only ever pulls low
  always_ff @(posedge clk_i) begin
    link_good_or_disable_o <= 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_check_en_o <= 1'b0;
    end else begin
      link_check_en_o <= (state_ff == nsi_pkg::ST_RUN) & ~link_disable_ff;
    end
  end

  // ----------------------------------------
  // port and squelch straps
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aui_select_o <= 1'b0;
      squelch_reduced_o <= 1'b1;
    end else begin
      aui_select_o <= port_s;
      squelch_reduced_o <= sq_s;
    end
  end

  // ----------------------------------------
  // 20 MHz output from the 40 MHz clock
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk20_o <= 1'b0;
    end else if (clk_en) begin
      clk20_o <= ~clk20_o;
    end else begin
      clk20_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // interrupt status
  // ----------------------------------------
  logic [`NSI_IRQ_W-1:0] irq_stat_ff;
  logic [`NSI_IRQ_W-1:0] irq_en_ff;
  logic [`NSI_IRQ_W-1:0] irq_set;
  logic [`NSI_IRQ_W-1:0] irq_clr;
  logic led_q_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      led_q_ff <= 1'b0;
    end else begin
      led_q_ff <= link_good_or_disable_oe_o;
    end
  end

  always_comb begin
    irq_set = '0;
    irq_set[`NSI_IRQ_TX] = evt_trig.tx;
    irq_set[`NSI_IRQ_COL] = evt_trig.col;
    irq_set[`NSI_IRQ_LINK] = led_q_ff ^ link_good_or_disable_oe_o;
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((irq_stat_ff & ~irq_clr) | irq_set) & irq_en_ff);
    end
  end

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  function automatic logic reg_hit(input logic [`NSI_ADR_W-1:0] adr, input logic [`NSI_ADR_W-1:0] ofs);
    reg_hit = (adr == ofs);
  endfunction

  logic wb_req;
  logic wb_wr;
  nsi_pkg::nsi_status_t status;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];
  assign irq_clr = (wb_wr && reg_hit(wb_adr_i, `NSI_OFS_IRQ_CLR)) ? wb_dat_i[`NSI_IRQ_W-1:0] : '0;

  always_comb begin
    status.tx = evt_active.tx;
    status.col = evt_active.col;
    status.link_good = link_good_or_disable_oe_o;
    status.link_dis = link_disable_ff;
    status.aui = aui_select_o;
    status.sq_red = squelch_reduced_o;
    status.test = test_s;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= `NSI_CTRL_RST;
      irq_en_ff <= `NSI_IRQ_EN_RST;
    end else if (wb_wr) begin
      if (reg_hit(wb_adr_i, `NSI_OFS_CTRL)) begin
        ctrl_ff <= wb_dat_i[`NSI_CTRL_W-1:0];
      end
      if (reg_hit(wb_adr_i, `NSI_OFS_IRQ_EN)) begin
        irq_en_ff <= wb_dat_i[`NSI_IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= '0;
      if (reg_hit(wb_adr_i, `NSI_OFS_STATUS)) begin
        wb_dat_o[`NSI_ST_W-1:0] <= status;
      end
      if (reg_hit(wb_adr_i, `NSI_OFS_CTRL)) begin
        wb_dat_o[`NSI_CTRL_W-1:0] <= ctrl_ff;
      end
      if (reg_hit(wb_adr_i, `NSI_OFS_IRQ_STAT)) begin
        wb_dat_o[`NSI_IRQ_W-1:0] <= irq_stat_ff;
      end
      if (reg_hit(wb_adr_i, `NSI_OFS_IRQ_EN)) begin
        wb_dat_o[`NSI_IRQ_W-1:0] <= irq_en_ff;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_tx_pulse;
    tx_event_i && ind_en |=> transmit_activity_out_o [*8];
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("transmit indicator not stretched");

  property p_col_pulse;
    col_event_i && ind_en |=> collision_out_o [*8];
  endproperty
  a_col_pulse: assert property (p_col_pulse) else $error("collision indicator not stretched");

  property p_release_sample;
    state_ff == nsi_pkg::ST_RESET |=> link_disable_ff == !$past(link_pin_s);
  endproperty
  a_release_sample: assert property (p_release_sample) else $error("link pin role not sampled");

  property p_led_follows_link;
    (state_ff == nsi_pkg::ST_RUN) && !link_disable_ff && !port_s |=>
      link_good_or_disable_oe_o == $past(link_good_i);
  endproperty
  a_led_follows_link: assert property (p_led_follows_link) else $error("good-link driver wrong");

  property p_led_low_only;
    link_good_or_disable_oe_o |-> !link_good_or_disable_o;
  endproperty
  a_led_low_only: assert property (p_led_low_only) else $error("link pin driven high");

  property p_aui_release;
    port_s |=> !link_good_or_disable_oe_o && aui_select_o;
  endproperty
  a_aui_release: assert property (p_aui_release) else $error("link driven in attachment mode");

  property p_disabled;
    link_disable_ff |=> !link_good_or_disable_oe_o && !link_check_en_o;
  endproperty
  a_disabled: assert property (p_disabled) else $error("link checking not disabled");

  property p_squelch;
    ##1 squelch_reduced_o == $past(sq_s);
  endproperty
  a_squelch: assert property (p_squelch) else $error("squelch select not applied");

  property p_clk_out;
    clk_en ##1 clk_en |-> clk20_o != $past(clk20_o);
  endproperty
  a_clk_out: assert property (p_clk_out) else $error("clock output not toggling");

  property p_port;
    !port_s ##1 !port_s |-> !aui_select_o;
  endproperty
  a_port: assert property (p_port) else $error("port routing wrong");

  property p_hold_decision;
    state_ff == nsi_pkg::ST_RUN |=> $stable(link_disable_ff);
  endproperty
  a_hold_decision: assert property (p_hold_decision) else $error("link decision changed");

  property p_reset_quiet;
    @(posedge clk_i) disable iff (1'b0)
      rst_i |=> !link_good_or_disable_oe_o && !wb_ack_o && !irq_o && !clk20_o;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active in reset");

  c_tx_led: cover property (transmit_activity_out_o && collision_out_o);
  c_link_dis: cover property ($rose(link_disable_ff));
  c_led_on: cover property ($rose(link_good_or_disable_oe_o));
  c_irq: cover property ($rose(irq_o));

endmodule

`default_nettype wire

// ==== status_board.sv ====
`default_nettype none

module status_board (
  // from the block
  input wire logic led_oe_i,
  // board strapping chosen by the bench
  input wire logic strap_low_i,
  input wire logic sq_open_i,
  input wire logic sq_level_i,
  // pin levels seen by the block
  output logic link_pin_o,
  output logic sq_pin_o,
  output logic test_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // open drain with pull-up: led drive or strap pulls low
  assign link_pin_o = (led_oe_i || strap_low_i) ? 1'b0 : 1'b1;
  // open select pin resolves high
  assign sq_pin_o = sq_open_i ? 1'b1 : sq_level_i;
  assign test_pin_o = 1'b0;
endmodule

`default_nettype wire

// ==== network_status_indicators_tb.sv ====
`include "nsi_map.svh"
`default_nettype none

module network_status_indicators_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 20;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, link_good_i, port_select_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  nsi_pkg::ind_evt_t evt;
  logic pin_link, pin_sq, pin_test, oe, oe_dat, tx_o, col_o, clk20, aui, sq_red, chk_en, prev;
  logic strap_low, sq_open, sq_level;
  logic [31:0] exp_q[$];
  int n_mismatch, total_checks, cyc, t0, seed;

  network_status_indicators #(.STRETCH_CYCLES(21'(N))) network_status_indicators_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .tx_event_i(evt.tx), .col_event_i(evt.col),
    .link_good_i(link_good_i), .link_good_or_disable_i(pin_link), .link_good_or_disable_o(oe_dat),
    .link_good_or_disable_oe_o(oe), .port_select_i(port_select_i), .squelch_level_select_i(pin_sq),
    .factory_test_i(pin_test), .transmit_activity_out_o(tx_o), .collision_out_o(col_o),
    .clk20_o(clk20), .aui_select_o(aui), .squelch_reduced_o(sq_red), .link_check_en_o(chk_en));

  status_board status_board_i (.led_oe_i(oe), .strap_low_i(strap_low), .sq_open_i(sq_open),
    .sq_level_i(sq_level), .link_pin_o(pin_link), .sq_pin_o(pin_sq), .test_pin_o(pin_test));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // reporting
  // ----------------------------------------
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task chk1(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %b seen %b", name, exp, got);
    end
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // read data monitor: oldest note against the acked word
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_cyc_i === 1'b1 && wb_we_i === 1'b0) begin
      if (exp_q.size() == 0) check("read_queue", 32'h0, 32'h1);
      else check("read_data", exp_q.pop_front(), wb_dat_o);
    end
  end

  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task wr(input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel = 4'hF);
    wb(1'b1, adr, dat, sel);
  endtask

  task rd(input logic [7:0] adr, input logic [31:0] exp);
    exp_q.push_back(exp);
    wb(1'b0, adr, 32'h0, 4'hF);
  endtask

  task settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task do_reset(input logic strap);
    strap_low <= strap;
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  task automatic stretch(input logic col, input int gap);
    int g;
    @(posedge clk_i);
    evt.col <= col;
    evt.tx <= ~col;
    @(posedge clk_i);
    evt <= '0;
    #1;
    t0 = cyc;
    chk1("ind_rise", 1'b1, col ? col_o : tx_o);
    if (gap > 0) begin
      repeat (gap - 1) @(posedge clk_i);
      evt.col <= col;
      evt.tx <= ~col;
      @(posedge clk_i);
      evt <= '0;
    end
    g = 0;
    while ((col ? col_o : tx_o) !== 1'b0 && g < 200) begin
      settle(1);
      g++;
    end
    check("ind_len", 32'(N + gap), 32'(cyc - t0));
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    seed = 32'he379018f;
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, port_select_i, strap_low, sq_level} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    evt = '0;
    link_good_i = 1'b1;
    sq_open = 1'b1;
    {n_mismatch, total_checks, cyc} = '0;
    do_reset(1'b0);
    settle(3);
    chk1("link_check", 1'b1, chk_en);
    chk1("led_oe", 1'b1, oe);
    chk1("led_drive", 1'b0, oe_dat);
    chk1("sq_reduced", 1'b1, sq_red);
    rd(`NSI_OFS_STATUS, 32'h24);
    rd(`NSI_OFS_CTRL, 32'h3);
    rd(`NSI_OFS_IRQ_EN, 32'h0);
    rd(8'h14, 32'h0);
    @(posedge clk_i);
    link_good_i <= 1'b0;
    settle(3);
    chk1("led_broken", 1'b0, oe);
    link_good_i <= 1'b1;
    port_select_i <= 1'b1;
    settle(5);
    chk1("led_aui", 1'b0, oe);
    chk1("aui_sel", 1'b1, aui);
    rd(`NSI_OFS_STATUS, 32'h30);
    port_select_i <= 1'b0;
    sq_open <= 1'b0;
    settle(5);
    chk1("sq_low", 1'b0, sq_red);
    chk1("aui_off", 1'b0, aui);
    sq_level <= 1'b1;
    settle(5);
    chk1("sq_high", 1'b1, sq_red);
    for (int i = 0; i < 2; i++) begin
      stretch(i[0], 0);
      stretch(i[0], 1 + int'($unsigned($random(seed)) % 8));
    end
    rd(`NSI_OFS_IRQ_STAT, 32'h7);
    wr(`NSI_OFS_IRQ_CLR, 32'h7);
    wr(`NSI_OFS_IRQ_EN, 32'h1);
    stretch(1'b0, 0);
    chk1("irq_set", 1'b1, irq_o);
    rd(`NSI_OFS_IRQ_STAT, 32'h1);
    wr(`NSI_OFS_IRQ_EN, 32'h0);
    settle(2);
    chk1("irq_mask", 1'b0, irq_o);
    wr(`NSI_OFS_IRQ_EN, 32'h1);
    settle(2);
    chk1("irq_unmask", 1'b1, irq_o);
    wr(`NSI_OFS_IRQ_CLR, 32'h1);
    settle(2);
    chk1("irq_clr", 1'b0, irq_o);
    rd(`NSI_OFS_IRQ_STAT, 32'h0);
    wr(`NSI_OFS_CTRL, 32'h2);
    rd(`NSI_OFS_CTRL, 32'h2);
    @(posedge clk_i);
    evt.tx <= 1'b1;
    @(posedge clk_i);
    evt <= '0;
    settle(2);
    chk1("ind_blocked", 1'b0, tx_o);
    for (int i = 0; i < 4; i++) begin
      prev = clk20;
      settle(1);
      chk1("clk20_toggle", ~prev, clk20);
    end
    wr(`NSI_OFS_CTRL, 32'h1);
    settle(3);
    chk1("clk20_off", 1'b0, clk20);
    wr(`NSI_OFS_CTRL, 32'h3, 4'hE);
    rd(`NSI_OFS_CTRL, 32'h1);
    wr(`NSI_OFS_CTRL, 32'h3);
    do_reset(1'b1);
    settle(3);
    chk1("dis_check", 1'b0, chk_en);
    chk1("dis_led", 1'b0, oe);
    rd(`NSI_OFS_STATUS, 32'h28);
    strap_low <= 1'b0;
    settle(6);
    chk1("dis_held", 1'b0, chk_en);
    do_reset(1'b0);
    settle(3);
    chk1("rearm", 1'b1, chk_en);
    report_and_stop();
  end
endmodule

`default_nettype wire
